// ==== src/stl_clamp.sv ====
/*
 One-direction clamp of torque magnitude against an effective percent limit.
 Assumes magnitude and limit in the same percent-of-rated units.
*/
`timescale 1ns/10ps
module stl_clamp
   import stl_pkg::*;
(
   input  wire logic [TQ_W-1:0]  magnitude,
   input  wire logic [PCT_W-1:0] int_limit,
   input  wire logic [PCT_W-1:0] ext_limit,
   input  wire logic             ext_on,
   output      logic [TQ_W-1:0]  clamped,
   output      logic             over
);
   logic [PCT_W-1:0] int_sat;
   logic [PCT_W-1:0] ext_sat;
   logic [PCT_W-1:0] eff;

   always_comb begin
      // Settings above maximum torque are held at maximum
      int_sat = (int_limit > MAX_TORQUE_PCT) ? MAX_TORQUE_PCT : int_limit;
      ext_sat = (ext_limit > MAX_TORQUE_PCT) ? MAX_TORQUE_PCT : ext_limit;
      eff = int_sat;
      if (ext_on && (ext_sat < int_sat)) begin
         eff = ext_sat;
      end
      over = magnitude > TQ_W'(eff);
      clamped = over ? TQ_W'(eff) : magnitude;
   end
endmodule

// ==== src/stl_pkg.sv ====
/*
 Constants and carrier types of the servo torque limit unit.
 Assumes one clock (mclk, 25 MHz) and synchronous active-high reset.
*/
// Behaviour
// - Clamp torque reference to forward or reverse internal limit by rotation.
// - Limits are percent of rated torque, 0 to maximum; internal default maximum.
// - Select 0: output active while speed at or above running level.
// - Select 1: output low while torque reference exceeds active limit.
// - Comparison limit is the lower of internal and external, external only while its request asserted.
// - Status bit and monitor word bit 4 follow the contact output.
// - External limits apply only when speed-control select bit 2 is 0.
// - Forward request low restricts forward torque to forward external limit.
// - Reverse request low restricts reverse torque to reverse external limit.
// - External limits range 0 to maximum, default 100 percent.
package stl_pkg;
   localparam int TQ_W = 16;
   localparam int PCT_W = 10;
   localparam int SPD_W = 16;
   localparam int MON_W = 16;
   localparam logic [PCT_W-1:0] MAX_TORQUE_PCT = 10'h12C;
   localparam logic [PCT_W-1:0] EXT_LIMIT_DEFAULT = 10'h064;
   localparam int SEL_OUT_BIT = 4;
   localparam int SEL_SPEED_BIT = 2;
   localparam int MON_LIMIT_BIT = 4;

   typedef struct packed {
      logic [PCT_W-1:0] fwd_internal_torque_limit;
      logic [PCT_W-1:0] rev_internal_torque_limit;
      logic [PCT_W-1:0] fwd_external_torque_limit;
      logic [PCT_W-1:0] rev_external_torque_limit;
   } stl_limits_t;

   typedef struct packed {
      logic [TQ_W-1:0] torque_out;
      logic            out_active;
      logic            limiting;
   } stl_state_t;
endpackage

// ==== src/stl_top.sv ====
/*
 Torque limit unit: clamps the signed torque reference to internal and
 external limits and drives the multiplexed limit/running contact output.
 Assumes all inputs synchronous to mclk; settings held by the caller.
*/
`timescale 1ns/10ps
module stl_top
   import stl_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire stl_pkg::stl_limits_t limits,
   input  wire logic [15:0]        config_switch_a,
   input  wire logic [15:0]        config_switch_b,
   input  wire logic [stl_pkg::TQ_W-1:0]  torque_ref,
   input  wire logic [stl_pkg::SPD_W-1:0] motor_speed,
   input  wire logic [stl_pkg::SPD_W-1:0] running_speed_level,
   input  wire logic               fwd_limit_request_n,
   input  wire logic               rev_limit_request_n,
   output      logic [stl_pkg::TQ_W-1:0]  torque_limited,
   output      logic               limit_or_running_output,
   output      logic               status_indication,
   output      logic [stl_pkg::MON_W-1:0] monitor_status_word,
   output      logic               torque_limiting
);
   import stl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   stl_state_t       st_r;
   stl_state_t       st_nxt;
   logic             reverse;
   logic [TQ_W-1:0]  mag;
   logic [TQ_W-1:0]  fwd_clamped;
   logic [TQ_W-1:0]  rev_clamped;
   logic             fwd_over;
   logic             rev_over;
   logic             ext_enable;
   logic             fwd_ext_on;
   logic             rev_ext_on;

   assign reverse = torque_ref[TQ_W-1];
   assign mag = reverse ? TQ_W'(-torque_ref) : torque_ref;
   assign ext_enable = ~config_switch_b[SEL_SPEED_BIT];
   assign fwd_ext_on = ext_enable & ~fwd_limit_request_n;
   assign rev_ext_on = ext_enable & ~rev_limit_request_n;

   stl_clamp u_fwd (
      .magnitude (mag),
      .int_limit (limits.fwd_internal_torque_limit),
      .ext_limit (limits.fwd_external_torque_limit),
      .ext_on    (fwd_ext_on),
      .clamped   (fwd_clamped),
      .over      (fwd_over)
   );

   stl_clamp u_rev (
      .magnitude (mag),
      .int_limit (limits.rev_internal_torque_limit),
      .ext_limit (limits.rev_external_torque_limit),
      .ext_on    (rev_ext_on),
      .clamped   (rev_clamped),
      .over      (rev_over)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      if (reverse) begin
         st_nxt.torque_out = TQ_W'(-rev_clamped);
         st_nxt.limiting = rev_over;
      end else begin
         st_nxt.torque_out = fwd_clamped;
         st_nxt.limiting = fwd_over;
      end
      // Active means contact closed, pin low
      if (config_switch_a[SEL_OUT_BIT]) begin
         st_nxt.out_active = st_nxt.limiting;
      end else begin
         st_nxt.out_active = motor_speed >= running_speed_level;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign torque_limited = st_r.torque_out;
   assign limit_or_running_output = ~st_r.out_active;
   assign status_indication = st_r.out_active;
   assign torque_limiting = st_r.limiting;
   always_comb begin
      monitor_status_word = '0;
      monitor_status_word[MON_LIMIT_BIT] = st_r.out_active;
   end
endmodule

// ==== verification/stl_host.sv ====
/* Host model of the limit requests; sampled on mclk. */
`timescale 1ns/10ps
module stl_host (
   input  wire logic mclk,
   output logic      fwd_limit_request_n = 1'h1,
   output logic      rev_limit_request_n = 1'h1
);
   always @(posedge mclk) begin
      fwd_limit_request_n <= 1'($urandom);
      rev_limit_request_n <= 1'($urandom);
   end
endmodule

// ==== verification/stl_top_properties.sv ====
/* Checker on stl_top ports; one clock, sync high reset. */
`timescale 1ns/10ps
module stl_chk
   import stl_pkg::*;
(
   input wire logic mclk, rst, rev_limit_request_n, torque_limiting,
   input wire logic limit_or_running_output, status_indication,
   input wire stl_limits_t limits,
   input wire logic [15:0] config_switch_a, config_switch_b, torque_ref,
   input wire logic [15:0] motor_speed, running_speed_level,
   input wire logic [15:0] torque_limited, monitor_status_word
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic fw = !torque_ref[15];
   AST_STAT: assert property (
      status_indication ^ limit_or_running_output) else $error("stat");
   AST_MON: assert property (
      monitor_status_word == 16'(status_indication) << 4) else $error("mon");
   AST_RUN: assert property (
      !config_switch_a[4] && motor_speed >= running_speed_level |=>
      !limit_or_running_output) else $error("run");
   AST_LIM: assert property (
      config_switch_a[4] |=> limit_or_running_output ^ torque_limiting)
      else $error("lim");
   AST_FWD: assert property (
      fw && torque_ref > limits.fwd_internal_torque_limit |=> torque_limiting
      && torque_limited <= $past(limits.fwd_internal_torque_limit))
      else $error("fwd");
   AST_REV: assert property (
      !config_switch_b[2] && !rev_limit_request_n && !fw &&
      -torque_ref > limits.rev_external_torque_limit |=> torque_limiting)
      else $error("rev");
   AST_PASS: assert property (
      config_switch_b[2] && fw && torque_ref <= MAX_TORQUE_PCT &&
      torque_ref <= limits.fwd_internal_torque_limit |=>
      torque_limited == $past(torque_ref)) else $error("pass");
   AST_EQ: assert property (
      config_switch_b[2] && fw && torque_ref <= MAX_TORQUE_PCT &&
      torque_ref == limits.fwd_internal_torque_limit |=> !torque_limiting)
      else $error("eq");
   cover property (torque_limiting);
   cover property (!config_switch_b[2] && !rev_limit_request_n);
   cover property (!config_switch_a[4] && !limit_or_running_output);
endmodule
bind stl_top stl_chk stl_chk_i (.*);

// ==== verification/stl_top_tb_top.sv ====
/* Random bench for stl_top; host model drives the requests. */
`timescale 1ns/10ps
module stl_top_tb_top;
   import stl_pkg::*;
   logic mclk = 0, rst = 1, fwd_limit_request_n, rev_limit_request_n;
   logic limit_or_running_output, status_indication, torque_limiting;
   stl_limits_t limits;
   logic [15:0] config_switch_a, config_switch_b, torque_ref, motor_speed;
   logic [15:0] running_speed_level, torque_limited, monitor_status_word;
   logic [17:0] exp;
   int err_count = 0, total_checks = 0, cyc = 0;
   stl_top stl_top_i (.*);
   stl_host stl_host_i (.*);
   initial forever #20 mclk = ~mclk;
   task chk(input string n, input logic [17:0] s, e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [15:0] sat(input logic [9:0] v);
      return v > MAX_TORQUE_PCT ? MAX_TORQUE_PCT : v;
   endfunction
   function automatic logic [17:0] model();
      logic [15:0] mg, lm, le;
      logic rv, rq, ov;
      rv = torque_ref[15];
      rq = rv ? rev_limit_request_n : fwd_limit_request_n;
      mg = rv ? -torque_ref : torque_ref;
      lm = sat(rv ? limits[29:20] : limits[39:30]);
      le = sat(rv ? limits[9:0] : limits[19:10]);
      if (!config_switch_b[2] && !rq && le < lm) lm = le;
      ov = mg > lm;
      return {config_switch_a[4] ? !ov : motor_speed < running_speed_level,
              ov, ov ? (rv ? -lm : lm) : torque_ref};
   endfunction
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc > 32'hBB8) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      {limits, config_switch_a, config_switch_b, torque_ref} = '0;
      {motor_speed, running_speed_level} = '0;
      void'($urandom(32'hCB84));
      repeat (16'h10) @(posedge mclk);
      chk("reset", {limit_or_running_output, torque_limiting, torque_limited},
          18'h20000);
      rst <= 1'h0;
      for (int i = 0; i < 32'h7D0; i++) begin
         @(posedge mclk);
         exp = model();
         if (i[1:0] == 2'h0) torque_ref <= 16'(limits[39:30]);
         else begin
            limits <= 40'({$urandom, $urandom}) & 40'h7FDFF7FDFF;
            torque_ref <= 16'($urandom_range(16'h320)) - 16'h190;
         end
         config_switch_a <= 16'($urandom);
         config_switch_b <= 16'($urandom);
         motor_speed <= 16'($urandom_range(16'h8));
         running_speed_level <= 16'($urandom_range(16'h8));
         #1 chk("out", {limit_or_running_output, torque_limiting,
                        torque_limited}, exp);
         chk("status", 18'(status_indication), 18'(!exp[17]));
         chk("monitor", 18'(monitor_status_word),
             18'({!exp[17], 4'h0}));
      end
      final_report();
   end
endmodule
